// File: hdl/pwen_notifier.sv
// per-port error detect and port-write notification block
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - oversize received packet sets flag, captures
// - link-response with idle ackID sets flag
// - unexpected packet/symbol sets protocol flag, captures
// - bad code-group sets delineation flag only
// - unsolicited acknowledge sets flag, captures
// - missing acknowledge in interval flags timeout
// - port interrupt enable gates interrupt and event-triggered sends, not timer resends
// - port-write on after reset, disable stops
// - all port-write events disabled after reset
// - enabled event sends port-write to target
// - disabled event sends no port-write
// - repeat events send despite set status
// - no extra send while one waits
// - resend while pending per timer field
// - one destination ID for all sources
// - source ID all ones per transport size
// - hop count set to 0xFF
// - sixteen byte payload with tag, errors
// - port-writes sent at priority zero
// - pending set on send, clear needs timer 0
module pwen_notifier #(
	parameter int TICK = pwen_pkg::TICK_CYC,
	parameter logic [7:0] PORT_NUM = 8'h00
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxPktEnd,
	input wire logic [pwen_pkg::LEN_W-1:0] rxPktLen,
	input wire logic linkRespValid,
	input wire logic [4:0] linkRespAckId,
	input wire logic [31:0] outstandingAckIds,
	input wire logic unexpectedRx,
	input wire logic badCodeGroup,
	input wire logic unsolicitedAck,
	input wire logic ackAwaited,
	input wire logic ackReceived,
	input wire logic linkInitDone,
	input wire logic [31:0] captureInfo,
	output logic globalInterruptReq,
	output logic pktValid,
	output pwen_pkg::pwen_word_s pktOut,
	input wire logic pktReady
);
	import pwen_pkg::*;

	generate
		if (TICK < 1 || TICK > 65536) begin : g_chk
			$error("TICK must be 1 to 65536 cycles");
		end
	endgenerate

	logic [ERR_N-1:0] errDet_reg, errDet_next;
	logic [EV_N-1:0] evEn_reg;
	logic [31:0] capt_reg;
	logic capValid_reg;
	logic [2:0] ctrl_reg;
	logic [15:0] target_reg;
	logic [CNT_W-1:0] ltCtl_reg;
	logic [TIMER_W-1:0] pwTimer_reg;
	logic pending_reg;
	logic linkInit_reg;
	logic [31:0] tag_reg;
	logic [31:0] rdata_reg;
	logic wrEn, apbSetup, mapped;
	logic [EV_N-1:0] ev;
	logic trigger, resendDue, sendReq_reg;
	logic [CNT_W-1:0] ltCnt_reg;
	logic [15:0] tickCnt_reg;
	logic tick;
	logic [TIMER_W-1:0] rsCnt_reg;
	pwen_state_e state_reg;
	logic [2:0] idx_reg;
	logic [31:0] snap_reg [0:3];
	logic [15:0] srcId;
	logic [1:0] tt;

	function automatic logic isMapped(input logic [7:0] a);
		isMapped = a == OFF_ERRDET || a == OFF_EVEN || a == OFF_CAPT
			|| a == OFF_CTRL || a == OFF_TARGET || a == OFF_LTCTL
			|| a == OFF_DISC || a == OFF_STAT || a == OFF_INTSTAT
			|| a == OFF_TAG;
	endfunction

	// apb slave, zero wait states
	assign mapped = isMapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign apbSetup = psel && !penable;
	assign wrEn = psel && penable && pwrite && mapped;
	assign prdata = rdata_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (apbSetup && !pwrite) begin
			unique case (paddr)
				OFF_ERRDET: rdata_reg <= 32'(errDet_reg);
				OFF_EVEN: rdata_reg <= 32'(evEn_reg);
				OFF_CAPT: rdata_reg <= capt_reg;
				OFF_CTRL: rdata_reg <= 32'(ctrl_reg);
				OFF_TARGET: rdata_reg <= 32'(target_reg);
				OFF_LTCTL: rdata_reg <= 32'(ltCtl_reg);
				OFF_DISC: rdata_reg <= 32'(pwTimer_reg);
				OFF_STAT: rdata_reg <= 32'({capValid_reg, pending_reg});
				OFF_INTSTAT: rdata_reg <= 32'(linkInit_reg);
				OFF_TAG: rdata_reg <= tag_reg;
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// control registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			evEn_reg <= EVEN_RST;
			ctrl_reg <= CTRL_RST[2:0];
			target_reg <= 16'h0000;
			ltCtl_reg <= '0;
			pwTimer_reg <= '0;
			tag_reg <= 32'h0000_0000;
		end else if (wrEn) begin
			unique case (paddr)
				OFF_EVEN: evEn_reg <= pwdata[EV_N-1:0];
				OFF_CTRL: ctrl_reg <= pwdata[2:0];
				OFF_TARGET: target_reg <= pwdata[15:0];
				OFF_LTCTL: ltCtl_reg <= pwdata[CNT_W-1:0];
				OFF_DISC: pwTimer_reg <= pwdata[TIMER_W-1:0];
				OFF_TAG: tag_reg <= pwdata;
				default: ;
			endcase
		end
	end

	// link time-out counter
	always_ff @(posedge clk_sys) begin
		if (!rst_n || ackReceived || !ackAwaited || ev[B_TMO]) begin
			ltCnt_reg <= '0;
		end else if (ltCtl_reg != '0) begin
			ltCnt_reg <= ltCnt_reg + 1'b1;
		end
	end

	// error events
	always_comb begin
		ev = '0;
		ev[B_OVERSIZE] = rxPktEnd && rxPktLen > LEN_W'(MAX_PKT_BYTES);
		ev[B_BADLR] = linkRespValid && !outstandingAckIds[linkRespAckId];
		ev[B_PROT] = unexpectedRx;
		ev[B_DELIN] = badCodeGroup;
		ev[B_UNSOL] = unsolicitedAck;
		ev[B_TMO] = ackAwaited && !ackReceived && ltCtl_reg != '0
			&& ltCnt_reg >= ltCtl_reg - 1'b1;
		ev[B_LINKINIT] = linkInitDone;
	end

	// sticky flags, set beats write-one-clear
	always_comb begin
		errDet_next = errDet_reg;
		if (wrEn && paddr == OFF_ERRDET) begin
			errDet_next = errDet_next & ~pwdata[ERR_N-1:0];
		end
		errDet_next = errDet_next | ev[ERR_N-1:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			errDet_reg <= '0;
		end else begin
			errDet_reg <= errDet_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			linkInit_reg <= 1'b0;
		end else if (ev[B_LINKINIT]) begin
			linkInit_reg <= 1'b1;
		end else if (wrEn && paddr == OFF_INTSTAT && pwdata[0]) begin
			linkInit_reg <= 1'b0;
		end
	end

	// capture, first capturable error holds until flags cleared
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			capt_reg <= 32'h0000_0000;
			capValid_reg <= 1'b0;
		end else if (!capValid_reg && (ev[B_OVERSIZE] || ev[B_PROT] || ev[B_UNSOL])) begin
			capt_reg <= captureInfo;
			capValid_reg <= 1'b1;
		end else if (errDet_next == '0) begin
			capValid_reg <= 1'b0;
		end
	end

	// interrupt propagation and triggers
	assign globalInterruptReq = ctrl_reg[C_IRQEN]
		&& |({linkInit_reg, errDet_reg} & evEn_reg);
	assign trigger = ctrl_reg[C_IRQEN] && !ctrl_reg[C_PWDIS]
		&& |(ev & evEn_reg);

	// resend tick divider and timer
	always_ff @(posedge clk_sys) begin
		if (!rst_n || tick) begin
			tickCnt_reg <= '0;
		end else begin
			tickCnt_reg <= tickCnt_reg + 1'b1;
		end
	end
	assign tick = tickCnt_reg == 16'(TICK - 1);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsCnt_reg <= '0;
		end else if (state_reg == ST_SEND || !pending_reg) begin
			rsCnt_reg <= '0;
		end else if (tick && !resendDue) begin
			rsCnt_reg <= rsCnt_reg + 1'b1;
		end
	end
	assign resendDue = pending_reg && pwTimer_reg != '0
		&& rsCnt_reg >= pwTimer_reg && state_reg == ST_IDLE;

	// request, one outstanding at most
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sendReq_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && sendReq_reg) begin
			sendReq_reg <= 1'b0;
		end else if ((trigger || resendDue) && !ctrl_reg[C_PWDIS]) begin
			sendReq_reg <= 1'b1;
		end
	end

	// pending flag, clear only with timer zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pending_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && sendReq_reg) begin
			pending_reg <= 1'b1;
		end else if (wrEn && paddr == OFF_STAT && pwdata[S_PEND] && pwTimer_reg == '0) begin
			pending_reg <= 1'b0;
		end
	end

	// packet header fields
	assign tt = ctrl_reg[C_LARGE] ? TT_LARGE : TT_SMALL;
	assign srcId = ctrl_reg[C_LARGE] ? SRC_LARGE : SRC_SMALL;

	// sender
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			idx_reg <= 3'h0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					idx_reg <= 3'h0;
					if (sendReq_reg) begin
						state_reg <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (pktReady) begin
						idx_reg <= idx_reg + 1'b1;
						if (idx_reg == PKT_WORDS - 1'b1) begin
							state_reg <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// payload snapshot at send start
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				snap_reg[i] <= 32'h0000_0000;
			end
		end else if (state_reg == ST_IDLE && sendReq_reg) begin
			snap_reg[0] <= tag_reg;
			snap_reg[1] <= 32'(errDet_reg);
			snap_reg[2] <= 32'(linkInit_reg) << PAY_LINKINIT;
			snap_reg[3] <= {PORT_NUM, 24'h00_0000};
		end
	end

	// output word register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pktOut <= '0;
		end else begin
			unique case (state_reg == ST_IDLE ? 3'h0 : (pktReady ? idx_reg + 1'b1 : idx_reg))
				3'h0: pktOut <= '{{PRIO_PW, tt, FTYPE_MAINT, 8'h00, target_reg}, 1'b0};
				3'h1: pktOut <= '{{srcId, TTYPE_PW, 4'h0, HOP_ALL}, 1'b0};
				3'h2: pktOut <= '{snap_reg[0], 1'b0};
				3'h3: pktOut <= '{snap_reg[1], 1'b0};
				3'h4: pktOut <= '{snap_reg[2], 1'b0};
				3'h5: pktOut <= '{snap_reg[3], 1'b1};
				default: pktOut <= '0;
			endcase
		end
	end
	assign pktValid = state_reg == ST_SEND;

	// rule checks and scenario covers
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	oversize_flag_a: assert property (ev[B_OVERSIZE] |=> errDet_reg[B_OVERSIZE])
		else $error("oversize flag not set");
	badlr_flag_a: assert property (linkRespValid && !outstandingAckIds[linkRespAckId] |=> errDet_reg[B_BADLR])
		else $error("bad link-response flag not set");
	capture_load_a: assert property (unexpectedRx && !capValid_reg |=> capValid_reg && capt_reg == $past(captureInfo))
		else $error("capture not loaded");
	delin_nocap_a: assert property (badCodeGroup && !rxPktEnd && !unexpectedRx && !unsolicitedAck
		|=> capt_reg == $past(capt_reg))
		else $error("delineation error loaded capture");
	irq_gate_a: assert property (!ctrl_reg[C_IRQEN] |-> !globalInterruptReq && !trigger)
		else $error("port interrupt disable leaked");
	pwdis_stop_a: assert property (ctrl_reg[C_PWDIS] && state_reg == ST_IDLE && !sendReq_reg
		&& $past(ctrl_reg[C_PWDIS]) |=> !pktValid)
		else $error("port-write sent while disabled");
	trig_send_a: assert property (trigger && state_reg == ST_IDLE && !sendReq_reg |=> ##1 pktValid)
		else $error("enabled event not sent");
	sticky_flag_a: assert property (errDet_reg[B_DELIN] && !(wrEn && paddr == OFF_ERRDET) |=> errDet_reg[B_DELIN])
		else $error("error flag dropped");
	pend_set_a: assert property (pktValid && idx_reg == 3'h0 |-> pending_reg)
		else $error("pending not set on send");
	pend_hold_a: assert property (pending_reg && pwTimer_reg != '0 |=> pending_reg)
		else $error("pending cleared with timer set");
	hdr_word_a: assert property (pktValid && idx_reg == 3'h1 |-> pktOut.data[7:0] == HOP_ALL
		&& pktOut.data[31:16] == srcId)
		else $error("bad source or hop field");
	prio_word_a: assert property (pktValid && idx_reg == 3'h0 |-> pktOut.data[31:30] == PRIO_PW
		&& pktOut.data[15:0] == target_reg)
		else $error("bad priority or destination");

	delin_flag_a: assert property (badCodeGroup |=> errDet_reg[B_DELIN])
		else $error("delineation flag not set");
	unsol_capture_a: assert property (unsolicitedAck && !capValid_reg |=> capValid_reg && capt_reg == $past(captureInfo))
		else $error("unsolicited acknowledge not captured");
	tmo_flag_a: assert property (ev[B_TMO] |=> errDet_reg[B_TMO])
		else $error("link time-out flag not set");
	one_request_a: assert property (state_reg == ST_IDLE && sendReq_reg |=> !sendReq_reg)
		else $error("extra port-write request kept");
	resend_req_a: assert property (resendDue && !sendReq_reg && !ctrl_reg[C_PWDIS] |=> sendReq_reg)
		else $error("resend not requested");
	port_word_a: assert property (pktValid && idx_reg == 3'h5 |-> pktOut.last
		&& pktOut.data == {PORT_NUM, 24'h00_0000})
		else $error("bad port number word");

	send_cov: cover property (pktValid && pktReady && pktOut.last);
	resend_cov: cover property (resendDue);
	tmo_cov: cover property (ev[B_TMO]);
	stall_cov: cover property (pktValid && !pktReady);
	linkinit_cov: cover property (ev[B_LINKINIT] && trigger);
endmodule
`default_nettype wire

// File: pkg/pwen_pkg.sv
// constants and types of the port-write error notifier
package pwen_pkg;
	localparam int CLK_MHZ = 100;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
	localparam int MAX_PKT_BYTES = 276;
	localparam int LEN_W = 12;
	localparam int CNT_W = 24;
	localparam logic [7:0] OFF_ERRDET = 8'h00;
	localparam logic [7:0] OFF_EVEN = 8'h04;
	localparam logic [7:0] OFF_CAPT = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0C;
	localparam logic [7:0] OFF_TARGET = 8'h10;
	localparam logic [7:0] OFF_LTCTL = 8'h14;
	localparam logic [7:0] OFF_DISC = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1C;
	localparam logic [7:0] OFF_INTSTAT = 8'h20;
	localparam logic [7:0] OFF_TAG = 8'h24;
	localparam int ERR_N = 6;
	localparam int EV_N = 7;
	localparam int B_OVERSIZE = 0;
	localparam int B_BADLR = 1;
	localparam int B_PROT = 2;
	localparam int B_DELIN = 3;
	localparam int B_UNSOL = 4;
	localparam int B_TMO = 5;
	localparam int B_LINKINIT = 6;
	localparam int C_IRQEN = 0;
	localparam int C_PWDIS = 1;
	localparam int C_LARGE = 2;
	localparam int S_PEND = 0;
	localparam int S_CAPV = 1;
	localparam int PAY_LINKINIT = 13;
	localparam int TIMER_W = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [EV_N-1:0] EVEN_RST = 7'h00;
	localparam logic [15:0] SRC_SMALL = 16'h00FF;
	localparam logic [15:0] SRC_LARGE = 16'hFFFF;
	localparam logic [7:0] HOP_ALL = 8'hFF;
	localparam logic [1:0] PRIO_PW = 2'h0;
	localparam logic [1:0] TT_SMALL = 2'h0;
	localparam logic [1:0] TT_LARGE = 2'h1;
	localparam logic [3:0] FTYPE_MAINT = 4'h8;
	localparam logic [3:0] TTYPE_PW = 4'h4;
	localparam logic [2:0] PKT_WORDS = 3'h6;
	typedef struct packed {
		logic [31:0] data;
		logic last;
	} pwen_word_s;
	typedef enum logic [0:0] {ST_IDLE, ST_SEND} pwen_state_e;
endpackage

// File: sim/pwen_notifier_tb.sv
// testbench of the port-write error notifier
`timescale 1ns/100ps
`default_nettype none
module pwen_notifier_tb;
	import pwen_pkg::*;
	localparam logic [7:0] PNUM = 8'h05;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, stall = 1'h0, ackAwaited = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, captureInfo = 32'h0, outstandingAckIds = 32'h0;
	logic [LEN_W-1:0] rxPktLen = 12'h000;
	logic [6:0] ev = 7'h00;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, globalInterruptReq, pktValid, pktReady, errv;
	pwen_word_s pktOut;
	int num_errors = 0;
	int compares = 0;
	int c;
	always #5 clk_sys = ~clk_sys;
	pwen_notifier #(.TICK(2), .PORT_NUM(PNUM)) u_pwen_notifier (
		.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxPktEnd(ev[0]), .rxPktLen(rxPktLen), .linkRespValid(ev[1]), .linkRespAckId(5'h03),
		.outstandingAckIds(outstandingAckIds), .unexpectedRx(ev[2]), .badCodeGroup(ev[3]),
		.unsolicitedAck(ev[4]), .ackAwaited(ackAwaited), .ackReceived(1'h0), .linkInitDone(ev[6]),
		.captureInfo(captureInfo), .globalInterruptReq(globalInterruptReq), .pktValid(pktValid),
		.pktOut(pktOut), .pktReady(pktReady)
	);
	pwen_sink u_pwen_sink (
		.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .pktValid(pktValid),
		.pktOut(pktOut), .pktReady(pktReady)
	);
	task automatic test_done();
		if (num_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n == 50) begin
			num_errors++;
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rdv & m, e);
	endtask
	task automatic evt(input int k, input int len);
		@(posedge clk_sys);
		ev <= 7'h01 << k;
		repeat (len) @(posedge clk_sys);
		ev <= 7'h00;
	endtask
	task automatic waitp(input int n);
		int k;
		k = 0;
		while (u_pwen_sink.pkts < n && k < 300) begin
			@(posedge clk_sys);
			k++;
		end
		if (k == 300) begin
			num_errors++;
			test_done();
		end
	endtask
	task automatic pkt(input int n, input logic [1:0] tt, input logic [15:0] src, input logic [31:0] im);
		waitp(n);
		chk(u_pwen_sink.words[0], {2'h0, tt, 4'h8, 8'h00, 16'h1234});
		chk(u_pwen_sink.words[1], {src, 4'h4, 4'h0, 8'hFF});
		chk(u_pwen_sink.words[2], 32'hC0DE0001);
		chk(u_pwen_sink.words[3], 32'h0000000C);
		chk(u_pwen_sink.words[4], im);
		chk(u_pwen_sink.words[5], {PNUM, 24'h000000});
	endtask
	task automatic s_reset();
		rd(OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rd(OFF_EVEN, 32'hFFFFFFFF, 32'h0);
		rd(8'h40, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, errv}, 32'h1);
	endtask
	task automatic s_errors();
		rxPktLen <= 12'h114;
		evt(0, 1);
		rd(OFF_ERRDET, 32'hFF, 32'h0);
		rxPktLen <= 12'h115;
		captureInfo <= 32'hA5A50001;
		evt(0, 1);
		rd(OFF_ERRDET, 32'hFF, 32'h1);
		outstandingAckIds <= 32'h8;
		evt(1, 1);
		rd(OFF_ERRDET, 32'hFF, 32'h1);
		outstandingAckIds <= 32'h0;
		captureInfo <= 32'h5A5A0002;
		evt(1, 1);
		evt(2, 1);
		evt(3, 1);
		evt(4, 1);
		rd(OFF_ERRDET, 32'hFF, 32'h1F);
		rd(OFF_CAPT, 32'hFFFFFFFF, 32'hA5A50001);
		wr(OFF_ERRDET, 32'h1F);
		rd(OFF_ERRDET, 32'hFF, 32'h0);
		evt(3, 1);
		captureInfo <= 32'h5A5A0003;
		evt(4, 1);
		rd(OFF_CAPT, 32'hFFFFFFFF, 32'h5A5A0003);
		wr(OFF_ERRDET, 32'h1F);
		wr(OFF_LTCTL, 32'h8);
		ackAwaited <= 1'h1;
		rd(OFF_ERRDET, 32'hFF, 32'h0);
		repeat (12) @(posedge clk_sys);
		ackAwaited <= 1'h0;
		rd(OFF_ERRDET, 32'hFF, 32'h20);
		wr(OFF_LTCTL, 32'h0);
		wr(OFF_ERRDET, 32'h3F);
	endtask
	task automatic s_notify();
		wr(OFF_TARGET, 32'h1234);
		wr(OFF_TAG, 32'hC0DE0001);
		wr(OFF_EVEN, 32'h44);
		evt(2, 1);
		repeat (10) @(posedge clk_sys);
		chk(u_pwen_sink.pkts, 32'h0);
		chk({31'h0, globalInterruptReq}, 32'h0);
		wr(OFF_CTRL, 32'h1);
		evt(3, 1);
		repeat (10) @(posedge clk_sys);
		chk(u_pwen_sink.pkts, 32'h0);
		chk({31'h0, globalInterruptReq}, 32'h1);
		evt(2, 1);
		pkt(1, 2'h0, 16'h00FF, 32'h0);
		rd(OFF_STAT, 32'h1, 32'h1);
		evt(2, 1);
		pkt(2, 2'h0, 16'h00FF, 32'h0);
		stall <= 1'h1;
		evt(2, 2);
		repeat (5) @(posedge clk_sys);
		chk({31'h0, pktValid}, 32'h1);
		stall <= 1'h0;
		pkt(3, 2'h0, 16'h00FF, 32'h0);
		repeat (30) @(posedge clk_sys);
		chk(u_pwen_sink.pkts, 32'h3);
		wr(OFF_CTRL, 32'h5);
		evt(6, 1);
		pkt(4, 2'h1, 16'hFFFF, 32'h2000);
	endtask
	task automatic s_resend();
		wr(OFF_DISC, 32'h2);
		wr(OFF_STAT, 32'h1);
		rd(OFF_STAT, 32'h1, 32'h1);
		pkt(5, 2'h1, 16'hFFFF, 32'h2000);
		wr(OFF_DISC, 32'h0);
		wr(OFF_STAT, 32'h1);
		rd(OFF_STAT, 32'h1, 32'h0);
		wr(OFF_CTRL, 32'h3);
		repeat (20) @(posedge clk_sys);
		c = u_pwen_sink.pkts;
		evt(2, 1);
		repeat (30) @(posedge clk_sys);
		chk(u_pwen_sink.pkts, c);
	endtask
	task automatic s_midreset();
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'h1;
		chk({31'h0, pktValid}, 32'h0);
		chk(pktOut.data, 32'h0);
		chk({31'h0, globalInterruptReq}, 32'h0);
		rd(OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rd(OFF_EVEN, 32'hFFFFFFFF, 32'h0);
		rd(OFF_TARGET, 32'hFFFFFFFF, 32'h0);
		wr(OFF_TARGET, 32'h1234);
		rd(OFF_TARGET, 32'hFFFF, 32'h1234);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
		s_reset();
		s_errors();
		s_notify();
		s_resend();
		s_midreset();
		test_done();
	end
endmodule
`default_nettype wire

// File: sim/pwen_sink.sv
// far-end model that takes port-write frames
`timescale 1ns/100ps
`default_nettype none
module pwen_sink (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic pktValid,
	input wire pwen_pkg::pwen_word_s pktOut,
	output logic pktReady
);
	import pwen_pkg::*;
	logic [31:0] words [0:5];
	int idx;
	int pkts;
	// ready is the registered inverse of stall, so it can answer promptly or slowly
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pktReady <= 1'h0;
			idx <= 0;
			pkts <= 0;
		end else begin
			pktReady <= !stall;
			if (pktValid && pktReady && idx < 6) begin
				words[idx] <= pktOut.data;
				idx <= pktOut.last ? 0 : idx + 1;
				pkts <= pktOut.last ? pkts + 1 : pkts;
			end
		end
	end
endmodule
`default_nettype wire
